// [shared/fpd_pkg.sv]
`default_nettype none
package fpd_pkg;
  // ==========================================================
  // Command code layout
  localparam int              FPD_CODE_W         = 4;
  localparam logic [3:0]      FPD_CODE_RAMP_STOP = 4'h0;
  localparam logic [3:0]      FPD_CODE_FIRST_FF  = 4'h1;
  localparam logic [3:0]      FPD_CODE_LAST_FF   = 4'he;
  localparam logic [3:0]      FPD_CODE_ALL_ONES  = 4'hf;
  localparam logic [1:0]      FPD_RUN_BITS_IDLE  = 2'h0;
  localparam int              FPD_NUM_CODES      = 16;

  // ==========================================================
  // Fixed frequency defaults in Hz
  localparam int              FPD_FF1_HZ         = 50;
  localparam int              FPD_FF2_HZ         = -50;
  localparam int              FPD_FF3_HZ         = 10;
  localparam int              FPD_FF_STEP_HZ     = 5;
  localparam int              FPD_SETPOINT_W     = 8;
  localparam int              FPD_SETPOINT_MIN_W = 8;

  // ==========================================================
  // Reset values
  localparam logic [3:0]      FPD_RST_CODE       = 4'h0;
  localparam logic            FPD_RST_FLAG       = 1'h0;

  // ==========================================================
  // Parameter channel message layout
  localparam int              FPD_MSG_W          = 16;
  localparam int              FPD_REQ_ID_MSB     = 15;
  localparam int              FPD_REQ_ID_LSB     = 12;
  localparam int              FPD_PNU_MSB        = 10;
  localparam int              FPD_PNU_LSB        = 0;
  localparam int              FPD_PAGE_MSB       = 15;
  localparam int              FPD_PAGE_LSB       = 10;
  localparam logic [3:0]      FPD_REQ_NONE       = 4'h0;
  localparam logic [3:0]      FPD_REQ_READ       = 4'h1;
  localparam logic [3:0]      FPD_REQ_DESC       = 4'h4;
  localparam logic [3:0]      FPD_REQ_READ_ARR   = 4'h6;
  localparam logic [3:0]      FPD_REQ_NUM_ELEM   = 4'h9;
  localparam logic [3:0]      FPD_REQ_STORE_LO   = 4'hb;
  localparam logic [3:0]      FPD_REQ_STORE_HI   = 4'he;

  // ==========================================================
  // Decoder states
  typedef enum logic {
    FPD_RUN,
    FPD_PI_ERROR
  } fpd_state_e;
endpackage
`default_nettype wire

// [src/fpd_param_channel.sv]
`timescale 1ns/1ps
`default_nettype none
module fpd_param_channel
  import fpd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        msg_valid,
  input  wire logic [15:0] msg_id_word,
  input  wire logic [15:0] msg_index_word,
  output logic             req_valid_reg,
  output logic [3:0]       req_id_reg,
  output logic [10:0]      param_number_reg,
  output logic [5:0]       param_page_reg,
  output logic             req_read_reg,
  output logic             req_write_reg,
  output logic             req_store_reg
);
  // ==========================================================
  // Field split of the single message format
  wire logic [3:0]  id_field   = msg_id_word[FPD_REQ_ID_MSB:FPD_REQ_ID_LSB];
  wire logic [10:0] pnu_field  = msg_id_word[FPD_PNU_MSB:FPD_PNU_LSB];
  wire logic [5:0]  page_field = msg_index_word[FPD_PAGE_MSB:FPD_PAGE_LSB];
  wire logic        is_read    = (id_field == FPD_REQ_READ) || (id_field == FPD_REQ_DESC) ||
                                 (id_field == FPD_REQ_READ_ARR) || (id_field == FPD_REQ_NUM_ELEM);
  wire logic        is_store   = (id_field >= FPD_REQ_STORE_LO) && (id_field <= FPD_REQ_STORE_HI);
  wire logic        is_write   = (id_field != FPD_REQ_NONE) && !is_read;

  // ==========================================================
  // Registered request
  always_ff @(posedge clk) begin
    if (srst) begin
      req_valid_reg    <= 1'h0;
      req_id_reg       <= 4'h0;
      param_number_reg <= 11'h000;
      param_page_reg   <= 6'h00;
      req_read_reg     <= 1'h0;
      req_write_reg    <= 1'h0;
      req_store_reg    <= 1'h0;
    end else begin
      req_valid_reg <= msg_valid && (id_field != FPD_REQ_NONE);
      if (msg_valid) begin
        req_id_reg       <= id_field;
        param_number_reg <= pnu_field;
        param_page_reg   <= page_field;
        req_read_reg     <= is_read;
        req_write_reg    <= is_write;
        req_store_reg    <= is_store;
      end
    end
  end

  // ==========================================================
  // Checks
  a_param_capture: assert property (@(posedge clk) disable iff (srst)
    msg_valid |=> param_number_reg == $past(msg_id_word[10:0]) && req_id_reg == $past(msg_id_word[15:12]))
    else $error("Parameter number not captured from message");
endmodule
`default_nettype wire

// [src/fpd_decoder.sv]
// Function
// - Code 0 gives ramp stop; codes 1..14 select that fixed frequency.
// - Setpoints: 50, -50, then 10 Hz rising by 5 Hz to 65 Hz.
// - Code all ones with an active trip acknowledges the fault.
// - Code all ones with no trip enters the process image error state.
// - Process image error turns off motor and brake outputs, like coast stop.
// - Error state holds until both run bits are low in one exchange.
// - Ready report bit shows whether the device accepts master commands.
// - Motor active report bit shows whether motor outputs are driving.
// - Report bits two and three copy local inputs one and two.
// - Dual-slave: bit two low keeps quick stop, high lets it be ignored.
// - Parameter requests use one message carrying the parameter number.
`timescale 1ns/1ps
`default_nettype none
module fpd_decoder
  import fpd_pkg::*;
#(
  parameter int SETPOINT_W = FPD_SETPOINT_W
) (
  input  wire logic                         clk,
  input  wire logic                         srst,
  input  wire logic                         exchange_done,
  input  wire logic                         command_bit_zero,
  input  wire logic                         command_bit_one,
  input  wire logic                         command_bit_two,
  input  wire logic                         command_bit_three,
  input  wire logic                         dual_slave_mode,
  input  wire logic                         slave1_command_bit_two,
  input  wire logic                         quick_stop_request,
  input  wire logic                         trip_active,
  input  wire logic                         device_ready,
  input  wire logic                         motor_driving,
  input  wire logic                         local_input_one,
  input  wire logic                         local_input_two,
  input  wire logic                         msg_valid,
  input  wire logic [15:0]                  msg_id_word,
  input  wire logic [15:0]                  msg_index_word,
  output logic                              ramp_stop_command,
  output logic                              coast_stop_command,
  output logic                              fault_ack_pulse,
  output logic                              pi_error,
  output logic [3:0]                        freq_select,
  output logic signed [SETPOINT_W-1:0]      freq_setpoint,
  output logic                              motor_output_enable,
  output logic                              brake_release,
  output logic                              quick_stop_active,
  output logic                              ready_report_bit,
  output logic                              motor_active_report_bit,
  output logic                              local_input_one_report_bit,
  output logic                              local_input_two_report_bit,
  output logic                              req_valid,
  output logic [3:0]                        req_id,
  output logic [10:0]                       param_number,
  output logic [5:0]                        param_page,
  output logic                              req_read,
  output logic                              req_write,
  output logic                              req_store
);
  // ==========================================================
  // Elaboration check
  if (SETPOINT_W < FPD_SETPOINT_MIN_W) begin : g_bad_width
    $error("SETPOINT_W too narrow for setpoint range");
  end

  // ==========================================================
  // Fixed frequency table
  logic signed [SETPOINT_W-1:0] ff_table [0:FPD_NUM_CODES-1];

  for (genvar i = 0; i < FPD_NUM_CODES; i++) begin : g_table
    if (i == 1) begin : g_ff1
      assign ff_table[i] = SETPOINT_W'(FPD_FF1_HZ);
    end else if (i == 2) begin : g_ff2
      assign ff_table[i] = SETPOINT_W'(FPD_FF2_HZ);
    end else if (i >= 3 && i <= 14) begin : g_ffn
      assign ff_table[i] = SETPOINT_W'(FPD_FF3_HZ + (i - 3) * FPD_FF_STEP_HZ);
    end else begin : g_none
      assign ff_table[i] = '0;
    end
  end

  // ==========================================================
  // Decode of the incoming code
  wire logic [3:0] code_in     = {command_bit_three, command_bit_two, command_bit_one, command_bit_zero};
  wire logic       code_stop   = (code_in == FPD_CODE_RAMP_STOP);
  wire logic       code_ff     = (code_in >= FPD_CODE_FIRST_FF) && (code_in <= FPD_CODE_LAST_FF);
  wire logic       code_ones   = (code_in == FPD_CODE_ALL_ONES);
  wire logic       ack_req     = exchange_done && code_ones && trip_active;
  wire logic       pi_enter    = exchange_done && code_ones && !trip_active;
  wire logic       run_idle    = ({command_bit_one, command_bit_zero} == FPD_RUN_BITS_IDLE);
  wire logic       pi_leave    = exchange_done && run_idle;
  wire logic       qs_ignored  = dual_slave_mode && slave1_command_bit_two;

  // ==========================================================
  // State machine
  fpd_state_e state_reg;
  fpd_state_e state_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FPD_RUN: begin
        if (pi_enter) begin
          state_next = FPD_PI_ERROR;
        end
      end
      FPD_PI_ERROR: begin
        if (pi_leave) begin
          state_next = FPD_RUN;
        end
      end
      default: begin
        state_next = FPD_RUN;
      end
    endcase
  end

  wire logic in_error_next = (state_next == FPD_PI_ERROR);
  wire logic take_code     = exchange_done && !in_error_next;

  // ==========================================================
  // Command registers
  logic [3:0]                   freq_select_reg;
  logic signed [SETPOINT_W-1:0] freq_setpoint_reg;
  logic                         ramp_stop_reg;
  logic                         fault_ack_reg;
  logic                         quick_stop_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= FPD_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      freq_select_reg   <= FPD_RST_CODE;
      freq_setpoint_reg <= '0;
      ramp_stop_reg     <= 1'h1;
    end else if (take_code) begin
      freq_select_reg   <= code_ff ? code_in : FPD_RST_CODE;
      freq_setpoint_reg <= ff_table[code_in];
      ramp_stop_reg     <= code_stop || !code_ff;
    end else if (in_error_next) begin
      freq_select_reg   <= FPD_RST_CODE;
      freq_setpoint_reg <= '0;
      ramp_stop_reg     <= FPD_RST_FLAG;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fault_ack_reg  <= FPD_RST_FLAG;
      quick_stop_reg <= FPD_RST_FLAG;
    end else begin
      fault_ack_reg <= ack_req;
      if (exchange_done) begin
        quick_stop_reg <= quick_stop_request && !qs_ignored;
      end
    end
  end

  // ==========================================================
  // Input process image
  logic ready_rep_reg;
  logic motor_rep_reg;
  logic in1_rep_reg;
  logic in2_rep_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      ready_rep_reg <= FPD_RST_FLAG;
      motor_rep_reg <= FPD_RST_FLAG;
      in1_rep_reg   <= FPD_RST_FLAG;
      in2_rep_reg   <= FPD_RST_FLAG;
    end else begin
      ready_rep_reg <= device_ready;
      motor_rep_reg <= motor_driving;
      in1_rep_reg   <= local_input_one;
      in2_rep_reg   <= local_input_two;
    end
  end

  // ==========================================================
  // Output assignments
  wire logic in_error = (state_reg == FPD_PI_ERROR);

  assign pi_error                   = in_error;
  assign coast_stop_command         = in_error;
  assign motor_output_enable        = !in_error;
  assign brake_release              = !in_error && !ramp_stop_reg;
  assign ramp_stop_command          = ramp_stop_reg;
  assign freq_select                = freq_select_reg;
  assign freq_setpoint              = freq_setpoint_reg;
  assign fault_ack_pulse            = fault_ack_reg;
  assign quick_stop_active          = quick_stop_reg;
  assign ready_report_bit           = ready_rep_reg;
  assign motor_active_report_bit    = motor_rep_reg;
  assign local_input_one_report_bit = in1_rep_reg;
  assign local_input_two_report_bit = in2_rep_reg;

  // ==========================================================
  // Parameter channel
  fpd_param_channel u_param (
    .clk              (clk),
    .srst             (srst),
    .msg_valid        (msg_valid),
    .msg_id_word      (msg_id_word),
    .msg_index_word   (msg_index_word),
    .req_valid_reg    (req_valid),
    .req_id_reg       (req_id),
    .param_number_reg (param_number),
    .param_page_reg   (param_page),
    .req_read_reg     (req_read),
    .req_write_reg    (req_write),
    .req_store_reg    (req_store)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_ramp_stop_code: assert property (
    exchange_done && code_stop && (!in_error || run_idle) |=> ramp_stop_command && freq_select == 4'h0)
    else $error("Code zero did not give ramp stop");

  a_ff_select_code: assert property (
    exchange_done && code_ff && !in_error |=> freq_select == $past(code_in) && !ramp_stop_command)
    else $error("Fixed frequency code not selected");

  a_setpoint_table: assert property (
    freq_select == 4'h3 |-> freq_setpoint == SETPOINT_W'(10))
    else $error("Fixed frequency 3 setpoint wrong");

  a_setpoint_ff2: assert property (
    freq_select == 4'h2 |-> freq_setpoint == SETPOINT_W'(-50))
    else $error("Fixed frequency 2 setpoint wrong");

  a_fault_ack_once: assert property (
    exchange_done && code_ones && trip_active |=> fault_ack_pulse && (pi_error == $past(pi_error)))
    else $error("Fault acknowledge not issued");

  a_pi_error_entry: assert property (
    exchange_done && code_ones && !trip_active |=> pi_error)
    else $error("Process image error not flagged");

  a_pi_coast_out: assert property (
    pi_error |-> !motor_output_enable && !brake_release && coast_stop_command)
    else $error("Outputs active during process image error");

  a_pi_hold_state: assert property (
    pi_error && !(exchange_done && run_idle) |=> pi_error)
    else $error("Process image error left early");

  a_cmd_hold_between: assert property (
    !exchange_done && !pi_error |=> $stable(freq_select) && $stable(freq_setpoint))
    else $error("Command changed between exchanges");

  a_ready_report: assert property (
    1'h1 |=> ready_report_bit == $past(device_ready))
    else $error("Ready report mismatch");

  a_motor_report: assert property (
    1'h1 |=> motor_active_report_bit == $past(motor_driving))
    else $error("Motor active report mismatch");

  a_local_report: assert property (
    1'h1 |=> local_input_one_report_bit == $past(local_input_one) &&
             local_input_two_report_bit == $past(local_input_two))
    else $error("Local input report mismatch");

  a_quick_stop_ovr: assert property (
    exchange_done && dual_slave_mode && slave1_command_bit_two |=> !quick_stop_active)
    else $error("Quick stop not overridden");

  c_ff_select: cover property (exchange_done && code_in == 4'he ##1 freq_select == 4'he);
  c_pi_round: cover property (pi_error ##[1:20] !pi_error);
  c_fault_ack: cover property (fault_ack_pulse);
  c_qs_ignored: cover property (exchange_done && dual_slave_mode && slave1_command_bit_two);
endmodule
`default_nettype wire

// [tb/fpd_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fpd_master_model (
  input  wire logic        clk,
  output var  logic        exchange_done,
  output var  logic        command_bit_zero,
  output var  logic        command_bit_one,
  output var  logic        command_bit_two,
  output var  logic        command_bit_three,
  output var  logic        msg_valid,
  output var  logic [15:0] msg_id_word,
  output var  logic [15:0] msg_index_word
);
  // ==========================================================
  // Idle values
  initial begin
    exchange_done = 1'b0;
    {command_bit_three, command_bit_two, command_bit_one, command_bit_zero} = 4'h0;
    msg_valid = 1'b0;
    msg_id_word = 16'h0000;
    msg_index_word = 16'h0000;
  end

  // ==========================================================
  // Process image: code held as a level, exchange strobed one cycle
  task automatic present_code(input logic [3:0] code);
    @(negedge clk);
    {command_bit_three, command_bit_two, command_bit_one, command_bit_zero} = code;
  endtask

  task automatic send_code(input logic [3:0] code);
    @(negedge clk);
    {command_bit_three, command_bit_two, command_bit_one, command_bit_zero} = code;
    exchange_done = 1'b1;
    @(negedge clk);
    exchange_done = 1'b0;
  endtask

  // ==========================================================
  // Parameter message: both words in one cycle, then invalidated
  task automatic send_msg(input logic [3:0] id, input logic [10:0] pnu, input logic [5:0] page);
    @(negedge clk);
    msg_id_word = {id, 1'b0, pnu};
    msg_index_word = {page, 10'h000};
    msg_valid = 1'b1;
    @(negedge clk);
    msg_valid = 1'b0;
    msg_id_word = ~msg_id_word;
    msg_index_word = ~msg_index_word;
  endtask
endmodule
`default_nettype wire

// [tb/fpd_decoder_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module fpd_decoder_bench;
  import fpd_pkg::*;
  logic              clk = 1'h0;
  logic              srst;
  logic              dual_slave_mode;
  logic              slave1_command_bit_two;
  logic              quick_stop_request;
  logic              trip_active;
  logic              device_ready;
  logic              motor_driving;
  logic              local_input_one;
  logic              local_input_two;
  wire logic         exchange_done, cb0, cb1, cb2, cb3, msg_valid;
  wire logic [15:0]  msg_id_word, msg_index_word;
  logic              ramp_stop_command, coast_stop_command, fault_ack_pulse, pi_error;
  logic [3:0]        freq_select, req_id;
  logic signed [7:0] freq_setpoint;
  logic              motor_output_enable, brake_release, quick_stop_active;
  wire logic [3:0]   rep;
  logic              req_valid, req_read, req_write, req_store;
  logic [10:0]       param_number;
  logic [5:0]        param_page;
  int                fails = 0;
  int                n_compared = 0;
  int                cycles = 0;
  int                sp;

  always #2.5 clk = ~clk;

  fpd_master_model MST (.clk(clk), .exchange_done(exchange_done), .command_bit_zero(cb0),
    .command_bit_one(cb1), .command_bit_two(cb2), .command_bit_three(cb3), .msg_valid(msg_valid),
    .msg_id_word(msg_id_word), .msg_index_word(msg_index_word));

  fpd_decoder DUT (.clk(clk), .srst(srst), .exchange_done(exchange_done), .command_bit_zero(cb0),
    .command_bit_one(cb1), .command_bit_two(cb2), .command_bit_three(cb3),
    .dual_slave_mode(dual_slave_mode), .slave1_command_bit_two(slave1_command_bit_two),
    .quick_stop_request(quick_stop_request), .trip_active(trip_active), .device_ready(device_ready),
    .motor_driving(motor_driving), .local_input_one(local_input_one), .local_input_two(local_input_two),
    .msg_valid(msg_valid), .msg_id_word(msg_id_word), .msg_index_word(msg_index_word),
    .ramp_stop_command(ramp_stop_command), .coast_stop_command(coast_stop_command),
    .fault_ack_pulse(fault_ack_pulse), .pi_error(pi_error), .freq_select(freq_select),
    .freq_setpoint(freq_setpoint), .motor_output_enable(motor_output_enable),
    .brake_release(brake_release), .quick_stop_active(quick_stop_active), .ready_report_bit(rep[3]),
    .motor_active_report_bit(rep[2]), .local_input_one_report_bit(rep[1]),
    .local_input_two_report_bit(rep[0]), .req_valid(req_valid), .req_id(req_id),
    .param_number(param_number), .param_page(param_page), .req_read(req_read),
    .req_write(req_write), .req_store(req_store));

  // ==========================================================
  // Checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      test_done();
    end
  end

  // ==========================================================
  // Tests
  initial begin
    srst = 1'h1;
    {dual_slave_mode, slave1_command_bit_two, quick_stop_request, trip_active} = 4'h0;
    {device_ready, motor_driving, local_input_one, local_input_two} = 4'h0;
    repeat (10) @(negedge clk);
    srst = 1'h0;
    check(16'({ramp_stop_command, brake_release, pi_error, motor_output_enable, freq_select}), 16'h0090);
    for (int c = 1; c <= 14; c++) begin
      MST.send_code(4'(c));
      sp = (c == 1) ? 50 : (c == 2) ? -50 : 10 + 5 * (c - 3);
      check(16'(freq_select), 16'(c));
      check(16'(freq_setpoint), 16'(sp));
      check(16'({ramp_stop_command, brake_release}), 16'h0001);
    end
    MST.send_code(4'h0);
    check(16'({ramp_stop_command, brake_release, freq_select}), 16'h0020);
    check(16'(freq_setpoint), 16'h0000);
    $display("test fixed frequencies done");
    MST.send_code(4'h3);
    MST.present_code(4'h9);
    repeat (3) @(negedge clk);
    check(16'(freq_select), 16'h0003);
    $display("test command hold done");
    @(negedge clk);
    trip_active = 1'b1;
    MST.send_code(4'hf);
    check(16'({fault_ack_pulse, pi_error}), 16'h0002);
    @(negedge clk);
    check(16'(fault_ack_pulse), 16'h0000);
    trip_active = 1'b0;
    $display("test fault acknowledge done");
    MST.send_code(4'hf);
    check(16'({pi_error, coast_stop_command}), 16'h0003);
    check(16'({motor_output_enable, brake_release}), 16'h0000);
    MST.send_code(4'h5);
    check(16'({pi_error, motor_output_enable, brake_release}), 16'h0004);
    MST.send_code(4'he);
    check(16'({pi_error, coast_stop_command}), 16'h0003);
    MST.send_code(4'h4);
    check(16'({pi_error, coast_stop_command, motor_output_enable}), 16'h0001);
    check(16'(freq_select), 16'h0004);
    check(16'(freq_setpoint), 16'h000f);
    MST.send_code(4'hf);
    @(negedge clk);
    srst = 1'h1;
    repeat (2) @(negedge clk);
    srst = 1'h0;
    check(16'({pi_error, coast_stop_command, ramp_stop_command, freq_select}), 16'h0010);
    $display("test process image error done");
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      {device_ready, motor_driving, local_input_one, local_input_two} = 4'(i);
      @(negedge clk);
      check(16'(rep), 16'(i));
    end
    $display("test report bits done");
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      {quick_stop_request, dual_slave_mode, slave1_command_bit_two} = 3'(i);
      MST.send_code(4'h0);
      check(16'(quick_stop_active), 16'(i >= 4 && i != 7));
    end
    $display("test quick stop done");
    for (int id = 0; id < 16; id++) begin
      MST.send_msg(4'(id), 11'(id * 100 + 5), 6'(id + 1));
      check(16'({req_valid, req_id}), 16'({id != 0, 4'(id)}));
      check(16'(param_number), 16'(id * 100 + 5));
      check(16'(param_page), 16'(id + 1));
      check(16'(req_read), 16'(id == 1 || id == 4 || id == 6 || id == 9));
      check(16'(req_store), 16'(id >= 11 && id <= 14));
      check(16'(req_write), 16'(id != 0 && !(id == 1 || id == 4 || id == 6 || id == 9)));
    end
    $display("test parameter messages done");
    test_done();
  end
endmodule
`default_nettype wire
